// [logic/mcs_main_clock_switch.sv]
// Overview of operation
// - After reset, CPU runs on internal oscillator; external paths stopped.
// - Mode bit 6 enables clock pins; bit 7 picks crystal or external clock.
// - Mode register takes exactly one 8-bit write after reset.
// - Three-bit stabilisation time select field in bits 2 to 0.
// - Clearing run-control bit 7 starts crystal or enables external clock input.
// - Read-only counter status shows elapsed-count flags in bits 7 to 0.
// - System clock bit 4 selects high-speed clock; bit 5 reports active source.
// - Halt instruction enters HALT from either clock state.
// - Flash code 10 is low-speed mode, 11 is high-speed mode.
// - Stopped external path leaves its pins in input port mode.
// - Switch runs on old source a few clocks; status follows afterwards.
// - Run-control bit 0 stops internal oscillator when set, runs it when clear.
`timescale 1ns/1ps
`default_nettype none
module mcs_main_clock_switch
   import mcs_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              osc_pin_i,
   input  wire logic [1:0]        flash_mode_code_i,
   input  wire logic              halt_exec_i,
   input  wire logic              wake_i,
   output logic                   internal_osc_run_o,
   output logic                   crystal_amp_enable_o,
   output logic                   high_gain_select_o,
   output logic                   ext_clock_input_enable_o,
   output logic                   pin_input_port_mode_o,
   output logic                   osc_stable_o,
   output logic                   cpu_gate_internal_o,
   output logic                   cpu_gate_external_o,
   output logic                   cpu_halt_o,
   output logic                   flash_low_speed_o,
   output logic                   flash_high_speed_o,
   output logic                   mode_write_refused_o
);

   mcs_bus_req_t          req;
   mcs_mode_t             clock_mode_control;
   logic                  mode_written;
   logic [STAB_SEL_W-1:0] stabilization_time_select;
   logic                  main_oscillator_stop;
   logic                  internal_oscillator_stop;
   logic                  main_clock_select;
   logic                  main_clock_status;
   logic [7:0]            stabilization_counter_status;
   logic                  ext_path_run;
   logic                  gate_int;
   logic                  gate_ext;
   logic [DATA_W-1:0]     next_rdata;

   assign req = '{addr:  addr_i,
                  wdata: wdata_i,
                  wr:    wr_i,
                  rd:    rd_i};

   // ==========================================================
   // Write strobe aimed at one register.
   // One shared compare keeps the register decodes from drifting apart.
   function automatic logic wr_hit(input mcs_bus_req_t r, input logic [ADDR_W-1:0] a);
      wr_hit = r.wr && (r.addr == a);
   endfunction

   // ==========================================================
   // Clock mode register.
   // single write only.
   // Later writes are dropped so a runaway program cannot retune the pins.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clock_mode_control <= mcs_mode_t'(CLOCK_MODE_RST);
      end else if (wr_hit(req, ADDR_CLOCK_MODE) && !mode_written) begin
         clock_mode_control <= mcs_mode_t'(req.wdata);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_written <= 1'b0;
      end else if (wr_hit(req, ADDR_CLOCK_MODE)) begin
         mode_written <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_write_refused_o <= 1'b0;
      end else begin
         mode_write_refused_o <= wr_hit(req, ADDR_CLOCK_MODE) && mode_written;
      end
   end

   // ==========================================================
   // stabilisation select field.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stabilization_time_select <= STAB_TIME_SEL_RST;
      end else if (wr_hit(req, ADDR_STAB_TIME_SEL)) begin
         stabilization_time_select <= req.wdata[STAB_SEL_W-1:0];
      end
   end

   // ==========================================================
   // Run control register.
   // reset oscillator state.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_oscillator_stop     <= OSC_RUN_RST[RUN_MAIN_STOP_BIT];
         internal_oscillator_stop <= OSC_RUN_RST[RUN_INT_STOP_BIT];
      end else if (wr_hit(req, ADDR_OSC_RUN)) begin
         main_oscillator_stop     <= req.wdata[RUN_MAIN_STOP_BIT];
         internal_oscillator_stop <= req.wdata[RUN_INT_STOP_BIT];
      end
   end

   // ==========================================================
   // System clock control register.
   // select bit write.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_clock_select <= 1'b0;
      end else if (wr_hit(req, ADDR_SYS_CLOCK)) begin
         main_clock_select <= req.wdata[SYS_SELECT_BIT];
      end
   end

   // ==========================================================
   // Oscillator and pin control.
   // start external path.
   assign ext_path_run = clock_mode_control.oscillator_pin_select && !main_oscillator_stop;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         crystal_amp_enable_o <= 1'b0;
      end else begin
         crystal_amp_enable_o <= ext_path_run && !clock_mode_control.external_input_select;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_clock_input_enable_o <= 1'b0;
      end else begin
         ext_clock_input_enable_o <= ext_path_run && clock_mode_control.external_input_select;
      end
   end

   // The gain stage is useless with a driven clock, so it stays off then.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         high_gain_select_o <= 1'b0;
      end else begin
         high_gain_select_o <= clock_mode_control.high_gain_select &&
                               !clock_mode_control.external_input_select;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_input_port_mode_o <= 1'b1;
      end else begin
         pin_input_port_mode_o <= !ext_path_run;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         internal_osc_run_o <= 1'b1;
      end else begin
         internal_osc_run_o <= !internal_oscillator_stop;
      end
   end

   // ==========================================================
   // Stabilisation counter.
   mcs_stab_counter u_stab (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .osc_run_i  (ext_path_run),
      .osc_pin_i  (osc_pin_i),
      .stab_sel_i (stabilization_time_select),
      .flags_o    (stabilization_counter_status),
      .stable_o   (osc_stable_o)
   );

   // ==========================================================
   // Source changeover.
   mcs_source_switch u_switch (
      .clk_i             (clk_i),
      .rst_i             (rst_i),
      .select_external_i (main_clock_select),
      .gate_internal_o   (gate_int),
      .gate_external_o   (gate_ext),
      .status_external_o (main_clock_status)
   );

   // internal gate follows oscillator.
   // A stopped source never gates the CPU clock on.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cpu_gate_internal_o <= 1'b1;
      end else begin
         cpu_gate_internal_o <= gate_int && !internal_oscillator_stop && !cpu_halt_o;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cpu_gate_external_o <= 1'b0;
      end else begin
         cpu_gate_external_o <= gate_ext && ext_path_run && !cpu_halt_o;
      end
   end

   // ==========================================================
   // halt entry.
   // Wake wins over a halt in the same cycle so a pending event is not slept through.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cpu_halt_o <= 1'b0;
      end else if (wake_i) begin
         cpu_halt_o <= 1'b0;
      end else if (halt_exec_i) begin
         cpu_halt_o <= 1'b1;
      end
   end

   // ==========================================================
   // flash mode decode.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flash_low_speed_o <= 1'b0;
      end else begin
         flash_low_speed_o <= flash_mode_code_i == FLASH_LOW_SPEED;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flash_high_speed_o <= 1'b0;
      end else begin
         flash_high_speed_o <= flash_mode_code_i == FLASH_HIGH_SPEED;
      end
   end

   // ==========================================================
   // Register read.
   // status read.
   always_comb begin
      next_rdata = ZERO_BYTE;
      case (req.addr)
         ADDR_CLOCK_MODE: begin
            next_rdata = DATA_W'(clock_mode_control);
         end
         ADDR_STAB_TIME_SEL: begin
            next_rdata[STAB_SEL_W-1:0] = stabilization_time_select;
         end
         ADDR_OSC_RUN: begin
            next_rdata[RUN_MAIN_STOP_BIT] = main_oscillator_stop;
            next_rdata[RUN_INT_STOP_BIT]  = internal_oscillator_stop;
         end
         ADDR_STAB_STATUS: begin
            next_rdata = stabilization_counter_status;
         end
         ADDR_SYS_CLOCK: begin
            next_rdata[SYS_SELECT_BIT] = main_clock_select;
            next_rdata[SYS_STATUS_BIT] = main_clock_status;
         end
         default: next_rdata = ZERO_BYTE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= ZERO_BYTE;
      end else if (req.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= ZERO_BYTE;
      end
   end

endmodule // mcs_main_clock_switch
`default_nettype wire

// [logic/mcs_pkg.sv]
`default_nettype none
package mcs_pkg;

   // ==========================================================
   // Register map and bus widths.
   localparam int          ADDR_W              = 8;
   localparam int          DATA_W              = 8;
   localparam logic [7:0]  ADDR_CLOCK_MODE     = 8'h00;
   localparam logic [7:0]  ADDR_STAB_TIME_SEL  = 8'h01;
   localparam logic [7:0]  ADDR_OSC_RUN        = 8'h02;
   localparam logic [7:0]  ADDR_STAB_STATUS    = 8'h03;
   localparam logic [7:0]  ADDR_SYS_CLOCK      = 8'h04;

   // ==========================================================
   // Field positions.
   localparam int          MODE_EXT_INPUT_BIT  = 7;
   localparam int          MODE_PIN_SEL_BIT    = 6;
   localparam int          MODE_GAIN_BIT       = 0;
   localparam int          RUN_MAIN_STOP_BIT   = 7;
   localparam int          RUN_INT_STOP_BIT    = 0;
   localparam int          SYS_SELECT_BIT      = 4;
   localparam int          SYS_STATUS_BIT      = 5;
   localparam int          STAB_SEL_W          = 3;

   // ==========================================================
   // Reset values.
   localparam logic [7:0]  CLOCK_MODE_RST      = 8'h00;
   localparam logic [2:0]  STAB_TIME_SEL_RST   = 3'h7;
   localparam logic [7:0]  OSC_RUN_RST         = 8'h80;
   localparam logic [7:0]  ZERO_BYTE           = 8'h00;

   // ==========================================================
   // Stabilisation counter: flag thresholds are powers of two of
   // oscillator edges; index 7 of the status byte is the shortest.
   localparam int          STAB_CNT_W          = 19;
   localparam int          STAB_EXP [8]        = '{18, 17, 15, 13, 11, 10, 9, 8};

   // ==========================================================
   // Timing of the source changeover.
   localparam int          CLK_MHZ             = 50;
   localparam int          SWITCH_HOLD_NS      = 40;
   localparam int          SWITCH_HOLD_CYC_RAW = (SWITCH_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int          SWITCH_HOLD_CYC     = (SWITCH_HOLD_CYC_RAW < 1) ? 1 : SWITCH_HOLD_CYC_RAW;
   localparam int          SWITCH_GAP_CYC      = 1;
   localparam int          SWITCH_CNT_W        = 4;
   localparam logic [3:0]  SWITCH_TOTAL        = 4'(SWITCH_HOLD_CYC + SWITCH_GAP_CYC);
   localparam logic [3:0]  SWITCH_GAP_AT       = 4'(SWITCH_GAP_CYC);

   // ==========================================================
   // Flash operation mode codes.
   localparam logic [1:0]  FLASH_LOW_SPEED     = 2'b10;
   localparam logic [1:0]  FLASH_HIGH_SPEED    = 2'b11;

   typedef struct packed {
      logic       external_input_select;
      logic       oscillator_pin_select;
      logic [4:0] unused;
      logic       high_gain_select;
   } mcs_mode_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mcs_bus_req_t;

   typedef enum logic [1:0] {
      SW_INTERNAL    = 2'b00,
      SW_TO_EXTERNAL = 2'b01,
      SW_EXTERNAL    = 2'b10,
      SW_TO_INTERNAL = 2'b11
   } mcs_sw_state_t;

   // Count has reached two to the power of the given exponent.
   function automatic logic stab_reached(input logic [STAB_CNT_W-1:0] cnt, input int e);
      stab_reached = |(cnt >> e);
   endfunction

endpackage
`default_nettype wire

// [logic/mcs_stab_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_stab_counter
   import mcs_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  osc_run_i,
   input  wire logic                  osc_pin_i,
   input  wire logic [STAB_SEL_W-1:0] stab_sel_i,
   output logic      [7:0]            flags_o,
   output logic                       stable_o
);

   logic                  sync1;
   logic                  sync2;
   logic                  sync3;
   logic                  level;
   logic [STAB_CNT_W-1:0] count;

   // ==========================================================
   // Pin synchroniser with agreement filter.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= osc_pin_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         level <= 1'b0;
      end else if (sync2 == sync3) begin
         level <= sync3;
      end
   end

   // ==========================================================
   // clear when stopped.
   // Saturates so the flags never fall back after a long wait.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count <= '0;
      end else if (!osc_run_i) begin
         count <= '0;
      end else if (sync2 == sync3 && sync3 && !level && !(&count)) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o <= ZERO_BYTE;
      end else begin
         for (int i = 0; i < 8; i++) begin
            flags_o[i] <= stab_reached(count, STAB_EXP[i]);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stable_o <= 1'b0;
      end else begin
         stable_o <= stab_reached(count, STAB_EXP[3'(7) - stab_sel_i]);
      end
   end

endmodule // mcs_stab_counter
`default_nettype wire

// [logic/mcs_source_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_source_switch
   import mcs_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic select_external_i,
   output logic      gate_internal_o,
   output logic      gate_external_o,
   output logic      status_external_o
);

   mcs_sw_state_t                state;
   mcs_sw_state_t                next_state;
   logic [SWITCH_CNT_W-1:0]      cnt;

   // ==========================================================
   // delayed changeover.
   always_comb begin
      next_state = state;
      case (state)
         SW_INTERNAL: begin
            if (select_external_i) next_state = SW_TO_EXTERNAL;
         end
         SW_TO_EXTERNAL: begin
            if (cnt == '0) next_state = SW_EXTERNAL;
         end
         SW_EXTERNAL: begin
            if (!select_external_i) next_state = SW_TO_INTERNAL;
         end
         SW_TO_INTERNAL: begin
            if (cnt == '0) next_state = SW_INTERNAL;
         end
         default: next_state = SW_INTERNAL;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= SW_INTERNAL;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else if (state != next_state && (next_state == SW_TO_EXTERNAL ||
                                           next_state == SW_TO_INTERNAL)) begin
         cnt <= SWITCH_TOTAL - 1'b1;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   // ==========================================================
   // break before make.
   // The old gate drops before the new one rises, so no runt pulse.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gate_internal_o <= 1'b1;
         gate_external_o <= 1'b0;
      end else begin
         // On entry the count is not loaded yet, so the old gate is kept then.
         gate_internal_o <= (next_state == SW_INTERNAL) ||
                            (next_state == SW_TO_EXTERNAL &&
                             (state != SW_TO_EXTERNAL || cnt > SWITCH_GAP_AT));
         gate_external_o <= (next_state == SW_EXTERNAL) ||
                            (next_state == SW_TO_INTERNAL &&
                             (state != SW_TO_INTERNAL || cnt > SWITCH_GAP_AT));
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_external_o <= 1'b0;
      end else begin
         status_external_o <= (next_state == SW_EXTERNAL) || (next_state == SW_TO_INTERNAL);
      end
   end

endmodule // mcs_source_switch
`default_nettype wire

// [verification/mcs_main_clock_switch_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the clock source switch.
module mcs_main_clock_switch_sva
   import mcs_pkg::*;
(
   input wire logic       clk_i, rst_i, wr_i, rd_i, halt_exec_i, wake_i,
   input wire logic [7:0] addr_i, wdata_i, rdata_o,
   input wire logic [1:0] flash_mode_code_i,
   input wire logic       internal_osc_run_o, crystal_amp_enable_o, high_gain_select_o,
   input wire logic       ext_clock_input_enable_o, pin_input_port_mode_o, osc_stable_o,
   input wire logic       cpu_gate_internal_o, cpu_gate_external_o, cpu_halt_o,
   input wire logic       flash_low_speed_o, flash_high_speed_o, mode_write_refused_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Remembers the first mode write, so a second one can be told apart.
   logic mode_done;
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i) mode_done <= 1'b0;
      else if (wr_i && addr_i == ADDR_CLOCK_MODE) mode_done <= 1'b1;

   sequence s_mode_wr;
      wr_i && addr_i == ADDR_CLOCK_MODE;
   endsequence
   sequence s_go_ext;
      wr_i && addr_i == ADDR_SYS_CLOCK && wdata_i[SYS_SELECT_BIT] && cpu_gate_internal_o
      && internal_osc_run_o && !cpu_halt_o && !halt_exec_i;
   endsequence
   sequence s_leave_int;
      $fell(cpu_gate_internal_o) && !cpu_halt_o && internal_osc_run_o
      && (crystal_amp_enable_o || ext_clock_input_enable_o);
   endsequence

   a_mode_refused: assert property (
      s_mode_wr ##0 mode_done |=> mode_write_refused_o) else $error("second write not flagged");
   a_mode_first: assert property (
      s_mode_wr ##0 !mode_done |=> !mode_write_refused_o) else $error("first write flagged");
   a_read_idle: assert property (
      !rd_i |=> rdata_o == ZERO_BYTE) else $error("read data outside read slot");
   a_gates_exclusive: assert property (
      !(cpu_gate_internal_o && cpu_gate_external_o)) else $error("both gates open");
   a_switch_hold: assert property (
      s_go_ext |=> cpu_gate_internal_o [*2]) else $error("old source left too early");
   a_switch_gap: assert property (
      s_leave_int |-> !cpu_gate_external_o ##1 cpu_gate_external_o) else $error("gap wrong");
   a_halt_entry: assert property (
      halt_exec_i && !wake_i |=> cpu_halt_o) else $error("halt not entered");
   a_halt_gates: assert property (
      cpu_halt_o [*2] |-> !cpu_gate_internal_o && !cpu_gate_external_o) else $error("halt gate");
   a_flash_low: assert property (
      (flash_mode_code_i == FLASH_LOW_SPEED) [*2] |-> flash_low_speed_o && !flash_high_speed_o)
      else $error("low speed mode wrong");
   a_flash_high: assert property (
      (flash_mode_code_i == FLASH_HIGH_SPEED) [*2] |-> flash_high_speed_o && !flash_low_speed_o)
      else $error("high speed mode wrong");
   a_ext_no_gain: assert property (
      ext_clock_input_enable_o |-> !high_gain_select_o && !crystal_amp_enable_o)
      else $error("amplifier on with external clock");
   a_port_mode: assert property (
      crystal_amp_enable_o || ext_clock_input_enable_o |-> !pin_input_port_mode_o)
      else $error("pins left in port mode");
   a_stab_running: assert property (
      $rose(osc_stable_o) |-> !pin_input_port_mode_o) else $error("stable while stopped");
endmodule // mcs_main_clock_switch_sva

bind mcs_main_clock_switch mcs_main_clock_switch_sva u_sva (.*);
`default_nettype wire

// [verification/mcs_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Crystal or external clock source at the oscillator pin.
module mcs_osc_model #(
   parameter int HALF_NS = 50
) (
   input  wire logic run_i,
   output logic      pin_o
);
   initial pin_o = 1'b0;
   always begin
      #(HALF_NS);
      if (run_i) pin_o = ~pin_o;
   end
   // Released pin drifts.
   // A stopped pin holds no real level, so the stale value is flipped once.
   always @(negedge run_i) pin_o = ~pin_o;
endmodule // mcs_osc_model
`default_nettype wire

// [verification/mcs_main_clock_switch_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_main_clock_switch_tb
   import mcs_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic       halt_exec_i = 1'b0;
   logic       wake_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [1:0] flash_mode_code_i = 2'b00;
   logic [7:0] rdata_o;
   logic       osc_pin_i, internal_osc_run_o, crystal_amp_enable_o, high_gain_select_o;
   logic       ext_clock_input_enable_o, pin_input_port_mode_o, osc_stable_o;
   logic       cpu_gate_internal_o, cpu_gate_external_o, cpu_halt_o;
   logic       flash_low_speed_o, flash_high_speed_o, mode_write_refused_o;
   int         n_errors = 0;
   int         checks_done = 0;
   wire logic [7:0] outs = {internal_osc_run_o, crystal_amp_enable_o, high_gain_select_o,
      ext_clock_input_enable_o, pin_input_port_mode_o, cpu_gate_internal_o,
      cpu_gate_external_o, cpu_halt_o};

   always #10 clk_i = ~clk_i;
   mcs_main_clock_switch dut (.*);
   mcs_osc_model #(.HALF_NS(50)) osc (.run_i(crystal_amp_enable_o | ext_clock_input_enable_o),
      .pin_o(osc_pin_i));

   task automatic give_verdict;
      $display("Checks made %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(what, exp, rdata_o);
   endtask
   task automatic halt_cycle(input logic [7:0] halted, input logic [7:0] running);
      @(posedge clk_i);
      halt_exec_i <= 1'b1;
      @(posedge clk_i);
      halt_exec_i <= 1'b0;
      tick(2);
      chk("halted", halted, outs);
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      tick(3);
      chk("woken", running, outs);
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      chk("outputs", 8'h8c, outs);
      rd(ADDR_CLOCK_MODE, CLOCK_MODE_RST, "mode");
      rd(ADDR_STAB_TIME_SEL, {5'h00, STAB_TIME_SEL_RST}, "select");
      rd(ADDR_OSC_RUN, OSC_RUN_RST, "run");
      wr(ADDR_STAB_STATUS, 8'hff);
      rd(ADDR_STAB_STATUS, 8'h00, "status");
      rd(ADDR_SYS_CLOCK, 8'h00, "sysclk");
      rd(8'h3c, 8'h00, "unmapped");
      halt_cycle(8'h89, 8'h8c);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         flash_mode_code_i <= 2'(i);
         tick(2);
         chk("flash", {6'h00, i == 3, i == 2}, {6'h00, flash_high_speed_o, flash_low_speed_o});
      end
      $display("t_reset done");
   endtask
   task automatic t_crystal;
      wr(ADDR_CLOCK_MODE, 8'h41);
      wr(ADDR_CLOCK_MODE, 8'h80);
      #1;
      chk("refused", 8'h01, {7'h00, mode_write_refused_o});
      rd(ADDR_CLOCK_MODE, 8'h41, "mode");
      chk("outputs", 8'hac, outs);
      wr(ADDR_STAB_TIME_SEL, 8'h00);
      rd(ADDR_STAB_TIME_SEL, 8'h00, "select");
      wr(ADDR_OSC_RUN, 8'h00);
      tick(2);
      chk("outputs", 8'he4, outs);
      for (int n = 0; n < 3000 && osc_stable_o !== 1'b1; n++) tick(1);
      chk("stable", 8'h01, {7'h00, osc_stable_o});
      rd(ADDR_STAB_STATUS, 8'h80, "status");
      wr(ADDR_SYS_CLOCK, 8'h10);
      tick(6);
      rd(ADDR_SYS_CLOCK, 8'h30, "sysclk");
      chk("outputs", 8'he2, outs);
      wr(ADDR_OSC_RUN, 8'h01);
      tick(2);
      chk("outputs", 8'h62, outs);
      halt_cycle(8'h61, 8'h62);
      wr(ADDR_OSC_RUN, 8'h00);
      wr(ADDR_SYS_CLOCK, 8'h00);
      tick(6);
      rd(ADDR_SYS_CLOCK, 8'h00, "sysclk");
      chk("outputs", 8'he4, outs);
      wr(ADDR_OSC_RUN, 8'h80);
      tick(3);
      chk("outputs", 8'hac, outs);
      rd(ADDR_STAB_STATUS, 8'h00, "status");
      wr(ADDR_OSC_RUN, 8'h00);
      tick(20);
      rd(ADDR_STAB_STATUS, 8'h00, "status");
      $display("t_crystal done");
   endtask
   task automatic t_external;
      wr(ADDR_CLOCK_MODE, 8'hc1);
      wr(ADDR_OSC_RUN, 8'h00);
      tick(2);
      chk("outputs", 8'h94, outs);
      wr(ADDR_SYS_CLOCK, 8'h10);
      tick(6);
      rd(ADDR_SYS_CLOCK, 8'h30, "sysclk");
      chk("outputs", 8'h92, outs);
      $display("t_external done");
   endtask

   initial begin
      do_reset();
      t_reset();
      t_crystal();
      do_reset();
      t_external();
      give_verdict();
   end
   // The run needs about 1450 cycles; ten times that is allowed before giving up.
   initial begin
      #300000;
      n_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule // mcs_main_clock_switch_tb
`default_nettype wire
